// >>> design/remote_port_pkg.sv
// Constants and types shared by the remote host access port
package remote_port_pkg;

  localparam int CMD_W = 3;
  localparam logic [2:0] CMD_INSTRUCTION_MEMORY = 3'h0;
  localparam logic [2:0] CMD_DATA_MEMORY = 3'h1;
  localparam logic [2:0] CMD_PC_LOW = 3'h2;
  localparam logic [2:0] CMD_PC_HIGH = 3'h3;
  localparam logic [2:0] CMD_CONFIG = 3'h4;

  // Remote interface config byte: three 2-bit wait-state fields
  localparam int WS_W = 2;
  localparam int IWS_LSB = 0;
  localparam int DWS_LSB = 2;
  localparam int LWS_LSB = 4;
  localparam logic [7:0] CONFIG_RESET = 8'h15;
  localparam logic [15:0] IA_RESET = 16'h0000;

  // One T-state is one device clock period
  localparam int CLK_PERIOD_NS = 50;
  localparam int T_STATE_NS = 50;
  localparam int T_STATE_CYC = (T_STATE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SYNC_DEPTH = 2;
  // Latest host release that costs no extra T-state
  localparam int RELEASE_LATE_NS = 45;
  localparam int RELEASE_LATE_RAW = RELEASE_LATE_NS / CLK_PERIOD_NS;
  localparam int RELEASE_LATE_CYC = (RELEASE_LATE_RAW < 1) ? 1 : RELEASE_LATE_RAW;
  localparam logic [2:0] HOST_LATE_CYC = 3'(SYNC_DEPTH + RELEASE_LATE_CYC);
  localparam logic [2:0] INSTRUCTION_MEMORY_SEIZE_T = 3'(T_STATE_CYC);
  localparam logic [2:0] REG_OWN_T = 3'(2 * T_STATE_CYC);

  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_SEIZE = 3'h1,
    ST_OWN = 3'h2,
    ST_ACK = 3'h3,
    ST_EXTRA = 3'h4,
    ST_RELEASE = 3'h5,
    ST_WAIT_HOST = 3'h6
  } state_type;

endpackage : remote_port_pkg

// >>> design/pin_sync.sv
// Two-flop synchroniser for pin inputs
`timescale 1ns/1ps
`default_nettype none
module pin_sync #(
  parameter int WIDTH = 1
) (
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic [WIDTH-1:0] async_i,
  input wire logic [WIDTH-1:0] reset_val_i,
  output logic [WIDTH-1:0] sync_o
);

  typedef struct packed {
    logic [WIDTH-1:0] first;
    logic [WIDTH-1:0] second;
  } sync_state_type;

  sync_state_type r;
  sync_state_type nxt;

  // First stage is read only by the second
  always_comb
  begin
    nxt.first = async_i;
    nxt.second = r.first;
  end

  // Reset value is a tie-off constant at the instance
  always_ff @(posedge clk_i)
  begin
    if (reset_i)
    begin
      r.first <= reset_val_i;
      r.second <= reset_val_i;
    end
    else
    begin
      r <= nxt;
    end
  end

  assign sync_o = r.second;

endmodule : pin_sync
`default_nettype wire

// >>> design/remote_host_access_port.sv
// Remote host access port: host reads and writes instruction memory and registers, writes data memory
`timescale 1ns/1ps
`default_nettype none
module remote_host_access_port (
  input wire logic REF_CLK_I,
  input wire logic RESET_I,
  input wire logic REMOTE_ACCESS_ENABLE_N_I,
  input wire logic REMOTE_READ_STROBE_N_I,
  input wire logic REMOTE_WRITE_STROBE_N_I,
  input wire logic [2:0] COMMAND_I,
  input wire logic [7:0] AD_I,
  output logic [7:0] AD_O,
  output logic AD_OE_N_O,
  output logic TRANSFER_WAIT_ACK_O,
  output logic LOCAL_BUS_OWNED_O,
  output logic [15:0] INSTRUCTION_ADDRESS_BUS_O,
  input wire logic [15:0] INSTR_DATA_I,
  output logic [15:0] INSTR_DATA_O,
  output logic INSTR_DATA_OE_N_O,
  output logic INSTR_MEM_WRITE_STROBE_N_O,
  output logic DATA_MEM_WRITE_N_O,
  output logic [7:0] DATA_MEM_DATA_O,
  output logic [7:0] REMOTE_INTERFACE_CONFIG_O
);

  typedef struct packed {
    remote_port_pkg::state_type st;
    logic [2:0] cnt;
    logic [2:0] hold;
    logic [2:0] since_lcl;
    logic [2:0] cmd;
    logic is_wr;
    logic rd_hi;
    logic wr_hi;
    logic [15:0] ia;
    logic [7:0] cfg;
    logic [7:0] lo_byte;
    logic [7:0] wdata;
    logic [7:0] ad_out;
  } port_state_type;

  port_state_type r;
  port_state_type nxt;

  logic [29:0] pins_s;
  logic en_n_s;
  logic rd_n_s;
  logic wr_n_s;
  logic [2:0] cmd_s;
  logic [7:0] ad_s;
  logic [15:0] idata_s;
  logic req;
  logic local_bus_owned;
  logic strobe_on;
  logic iwr_on;
  logic dwr_on;
  logic ad_drive;
  logic instruction_memory_hi_wr;

  // Wait-state field of the config byte, widened for counting
  function automatic logic [2:0] ws_field(input logic [7:0] cfg, input int lsb);
    ws_field = {1'b0, cfg[lsb +: remote_port_pkg::WS_W]};
  endfunction : ws_field

  // Pins cross into the clock domain; strobes idle high
  pin_sync #(
    .WIDTH(30)
  ) u_pin_sync (
    .clk_i(REF_CLK_I),
    .reset_i(RESET_I),
    .async_i({REMOTE_ACCESS_ENABLE_N_I, REMOTE_READ_STROBE_N_I, REMOTE_WRITE_STROBE_N_I,
      COMMAND_I, AD_I, INSTR_DATA_I}),
    .reset_val_i({3'h7, 27'h0000000}),
    .sync_o(pins_s)
  );

  assign en_n_s = pins_s[29];
  assign rd_n_s = pins_s[28];
  assign wr_n_s = pins_s[27];
  assign cmd_s = pins_s[26:24];
  assign ad_s = pins_s[23:16];
  assign idata_s = pins_s[15:0];

  // Command sampled with the strobe; host keeps it stable a T-state
  assign req = !en_n_s && (!rd_n_s || !wr_n_s);

  always_comb
  begin
    logic [2:0] seize_len;
    logic [2:0] own_len;
    logic [7:0] rbyte;
    nxt = r;
    seize_len = 3'h0;
    own_len = 3'h0;
    rbyte = 8'h00;
    if (r.cmd == remote_port_pkg::CMD_INSTRUCTION_MEMORY)
    begin
      seize_len = remote_port_pkg::INSTRUCTION_MEMORY_SEIZE_T;
    end
    else
    begin
      seize_len = ws_field(r.cfg, remote_port_pkg::LWS_LSB) + 3'h1;
    end
    if (r.cmd == remote_port_pkg::CMD_INSTRUCTION_MEMORY && !(r.is_wr && !r.wr_hi))
    begin
      own_len = ws_field(r.cfg, remote_port_pkg::IWS_LSB) + 3'h2;
    end
    else if (r.cmd == remote_port_pkg::CMD_DATA_MEMORY)
    begin
      own_len = ws_field(r.cfg, remote_port_pkg::DWS_LSB) + 3'h2;
    end
    else
    begin
      own_len = remote_port_pkg::REG_OWN_T;
    end
    unique case (r.cmd)
      remote_port_pkg::CMD_INSTRUCTION_MEMORY: rbyte = r.rd_hi ? idata_s[15:8] : idata_s[7:0];
      remote_port_pkg::CMD_PC_LOW: rbyte = r.ia[7:0];
      remote_port_pkg::CMD_PC_HIGH: rbyte = r.ia[15:8];
      remote_port_pkg::CMD_CONFIG: rbyte = r.cfg;
      default: rbyte = 8'h00;
    endcase
    if (r.since_lcl != 3'h7)
    begin
      nxt.since_lcl = r.since_lcl + 3'h1;
    end
    unique case (r.st)
      remote_port_pkg::ST_IDLE:
      begin
        if (req)
        begin
          nxt.st = remote_port_pkg::ST_SEIZE;
          nxt.cmd = cmd_s;
          nxt.is_wr = !wr_n_s;
          nxt.cnt = 3'h0;
        end
      end
      remote_port_pkg::ST_SEIZE:
      begin
        nxt.cnt = r.cnt + 3'h1;
        if (r.cnt >= seize_len - 3'h1)
        begin
          nxt.st = remote_port_pkg::ST_OWN;
          nxt.cnt = 3'h0;
          nxt.since_lcl = 3'h0;
        end
      end
      remote_port_pkg::ST_OWN:
      begin
        nxt.cnt = r.cnt + 3'h1;
        nxt.wdata = ad_s;
        if (r.cnt >= own_len - 3'h1)
        begin
          nxt.st = remote_port_pkg::ST_ACK;
          nxt.hold = 3'h0;
        end
      end
      remote_port_pkg::ST_ACK:
      begin
        if (!r.is_wr)
        begin
          // Byte stays one more cycle, then bus goes back
          nxt.st = remote_port_pkg::ST_WAIT_HOST;
          if (r.cmd == remote_port_pkg::CMD_INSTRUCTION_MEMORY)
          begin
            nxt.rd_hi = !r.rd_hi;
            if (r.rd_hi)
            begin
              nxt.ia = r.ia + 16'h0001;
            end
          end
        end
        else if (req)
        begin
          // Keep the last byte seen while the host still strobes
          nxt.wdata = ad_s;
          if (r.hold != 3'h7)
          begin
            nxt.hold = r.hold + 3'h1;
          end
        end
        else
        begin
          if (r.hold > remote_port_pkg::HOST_LATE_CYC)
          begin
            nxt.st = remote_port_pkg::ST_EXTRA;
          end
          else
          begin
            nxt.st = remote_port_pkg::ST_RELEASE;
          end
          unique case (r.cmd)
            remote_port_pkg::CMD_INSTRUCTION_MEMORY:
            begin
              nxt.wr_hi = !r.wr_hi;
              if (!r.wr_hi)
              begin
                nxt.lo_byte = r.wdata;
              end
              else
              begin
                nxt.ia = r.ia + 16'h0001;
              end
            end
            remote_port_pkg::CMD_PC_LOW: nxt.ia[7:0] = r.wdata;
            remote_port_pkg::CMD_PC_HIGH: nxt.ia[15:8] = r.wdata;
            remote_port_pkg::CMD_CONFIG: nxt.cfg = r.wdata;
            default: nxt.cfg = r.cfg;
          endcase
        end
      end
      remote_port_pkg::ST_EXTRA: nxt.st = remote_port_pkg::ST_RELEASE;
      remote_port_pkg::ST_RELEASE: nxt.st = remote_port_pkg::ST_IDLE;
      remote_port_pkg::ST_WAIT_HOST:
      begin
        if (!req)
        begin
          nxt.st = remote_port_pkg::ST_IDLE;
        end
      end
      default: nxt.st = remote_port_pkg::ST_IDLE;
    endcase
    // Read byte shown while owned; otherwise the low address
    if ((nxt.st == remote_port_pkg::ST_OWN || nxt.st == remote_port_pkg::ST_ACK) && !nxt.is_wr)
    begin
      nxt.ad_out = rbyte;
    end
    else
    begin
      nxt.ad_out = nxt.ia[7:0];
    end
  end

  always_ff @(posedge REF_CLK_I)
  begin
    if (RESET_I)
    begin
      r.st <= remote_port_pkg::ST_IDLE;
      r.cnt <= 3'h0;
      r.hold <= 3'h0;
      r.since_lcl <= 3'h7;
      r.cmd <= remote_port_pkg::CMD_INSTRUCTION_MEMORY;
      r.is_wr <= 1'b0;
      r.rd_hi <= 1'b0;
      r.wr_hi <= 1'b0;
      r.ia <= remote_port_pkg::IA_RESET;
      r.cfg <= remote_port_pkg::CONFIG_RESET;
      r.lo_byte <= 8'h00;
      r.wdata <= 8'h00;
      r.ad_out <= 8'h00;
    end
    else
    begin
      r <= nxt;
    end
  end

  assign local_bus_owned = r.st == remote_port_pkg::ST_OWN || r.st == remote_port_pkg::ST_ACK ||
    r.st == remote_port_pkg::ST_EXTRA || r.st == remote_port_pkg::ST_RELEASE;
  assign instruction_memory_hi_wr = r.cmd == remote_port_pkg::CMD_INSTRUCTION_MEMORY && r.wr_hi;
  // Strobe from one T after seize until the host lets go
  assign strobe_on = r.is_wr && ((r.st == remote_port_pkg::ST_OWN && r.cnt != 3'h0) ||
    r.st == remote_port_pkg::ST_ACK);
  assign iwr_on = strobe_on && instruction_memory_hi_wr;
  assign dwr_on = strobe_on && r.cmd == remote_port_pkg::CMD_DATA_MEMORY;
  // Read data phase drives; release cycle drives before bus goes back
  assign ad_drive = !local_bus_owned || r.st == remote_port_pkg::ST_RELEASE ||
    (!r.is_wr && ((r.st == remote_port_pkg::ST_OWN && r.cnt != 3'h0) ||
    r.st == remote_port_pkg::ST_ACK));

  assign AD_O = r.ad_out;
  assign AD_OE_N_O = !ad_drive;
  assign TRANSFER_WAIT_ACK_O = !(r.st == remote_port_pkg::ST_SEIZE ||
    r.st == remote_port_pkg::ST_OWN);
  assign LOCAL_BUS_OWNED_O = local_bus_owned;
  assign INSTRUCTION_ADDRESS_BUS_O = r.ia;
  assign INSTR_DATA_O = {r.wdata, r.lo_byte};
  assign INSTR_DATA_OE_N_O = !iwr_on;
  assign INSTR_MEM_WRITE_STROBE_N_O = !iwr_on;
  assign DATA_MEM_WRITE_N_O = !dwr_on;
  assign DATA_MEM_DATA_O = r.wdata;
  assign REMOTE_INTERFACE_CONFIG_O = r.cfg;

  a_ack_on_request: assert property (@(posedge REF_CLK_I) disable iff (RESET_I)
    r.st == remote_port_pkg::ST_IDLE && req |=> !TRANSFER_WAIT_ACK_O)
    else $error("acknowledge did not drop on request");

  a_instruction_memory_seize_time: assert property (@(posedge REF_CLK_I) disable iff (RESET_I)
    $fell(TRANSFER_WAIT_ACK_O) && r.cmd == remote_port_pkg::CMD_INSTRUCTION_MEMORY
    |-> !LOCAL_BUS_OWNED_O ##1 LOCAL_BUS_OWNED_O)
    else $error("instruction access seized bus at wrong time");

  a_data_memory_seize_time: assert property (@(posedge REF_CLK_I) disable iff (RESET_I)
    $fell(TRANSFER_WAIT_ACK_O) && r.cmd == remote_port_pkg::CMD_DATA_MEMORY &&
    r.cfg[remote_port_pkg::LWS_LSB +: 2] == 2'h1
    |-> !LOCAL_BUS_OWNED_O [*2] ##1 LOCAL_BUS_OWNED_O)
    else $error("data access seized bus at wrong time");

  a_float_on_seize: assert property (@(posedge REF_CLK_I) disable iff (RESET_I)
    $rose(LOCAL_BUS_OWNED_O) |-> AD_OE_N_O) else $error("bus not floated on seize");

  a_drive_before_release: assert property (@(posedge REF_CLK_I) disable iff (RESET_I)
    $fell(LOCAL_BUS_OWNED_O) |-> $past(AD_OE_N_O) == 1'b0) else $error("bus not driven before release");

  a_read_byte_phase: assert property (@(posedge REF_CLK_I) disable iff (RESET_I)
    $rose(LOCAL_BUS_OWNED_O) && !r.is_wr |=> !AD_OE_N_O)
    else $error("read byte not driven one T-state after seize");

  a_instruction_memory_ack_time: assert property (@(posedge REF_CLK_I) disable iff (RESET_I)
    $rose(TRANSFER_WAIT_ACK_O) && r.cmd == remote_port_pkg::CMD_INSTRUCTION_MEMORY &&
    !(r.is_wr && !r.wr_hi)
    |-> r.since_lcl == ws_field(r.cfg, remote_port_pkg::IWS_LSB) + 3'h2)
    else $error("instruction acknowledge at wrong time");

  a_read_data_hold: assert property (@(posedge REF_CLK_I) disable iff (RESET_I)
    $rose(TRANSFER_WAIT_ACK_O) && !r.is_wr |-> !AD_OE_N_O && $stable(AD_O))
    else $error("read byte not held after acknowledge");

  a_ia_advance: assert property (@(posedge REF_CLK_I) disable iff (RESET_I)
    $fell(LOCAL_BUS_OWNED_O) && !r.is_wr && r.cmd == remote_port_pkg::CMD_INSTRUCTION_MEMORY
    |-> INSTRUCTION_ADDRESS_BUS_O == $past(INSTRUCTION_ADDRESS_BUS_O) + (r.rd_hi ? 16'h0 : 16'h1))
    else $error("instruction address advanced on wrong byte");

  a_release_after_host: assert property (@(posedge REF_CLK_I) disable iff (RESET_I)
    r.st == remote_port_pkg::ST_ACK && r.is_wr && !req &&
    r.hold <= remote_port_pkg::HOST_LATE_CYC |=> LOCAL_BUS_OWNED_O ##1 !LOCAL_BUS_OWNED_O)
    else $error("bus not released one T-state after host release");

  a_late_extra_state: assert property (@(posedge REF_CLK_I) disable iff (RESET_I)
    r.st == remote_port_pkg::ST_ACK && r.is_wr && !req &&
    r.hold > remote_port_pkg::HOST_LATE_CYC |=> LOCAL_BUS_OWNED_O [*2] ##1 !LOCAL_BUS_OWNED_O)
    else $error("late release did not add a T-state");

  a_strobe_start: assert property (@(posedge REF_CLK_I) disable iff (RESET_I)
    $fell(DATA_MEM_WRITE_N_O) || $fell(INSTR_MEM_WRITE_STROBE_N_O) |-> r.since_lcl == 3'h1)
    else $error("write strobe not one T-state after seize");

  a_strobe_until_host: assert property (@(posedge REF_CLK_I) disable iff (RESET_I)
    !DATA_MEM_WRITE_N_O && TRANSFER_WAIT_ACK_O && req |=> !DATA_MEM_WRITE_N_O)
    else $error("data strobe ended before host release");

  a_idrv_follows: assert property (@(posedge REF_CLK_I) disable iff (RESET_I)
    $fell(INSTR_MEM_WRITE_STROBE_N_O) |-> !INSTR_DATA_OE_N_O ##1
    (!INSTR_DATA_OE_N_O)[*1] ##0 !INSTR_MEM_WRITE_STROBE_N_O)
    else $error("instruction drivers not enabled with strobe");

endmodule : remote_host_access_port
`default_nettype wire

// >>> dv/host_model.sv
// Host model: one remote access at a time on enable and strobes
`timescale 1ns/1ps
`default_nettype none
module host_model (
  input wire logic clk_i,
  input wire logic ack_i,
  input wire logic [7:0] ad_i,
  output logic enable_n_o,
  output logic rd_n_o,
  output logic wr_n_o,
  output logic [2:0] cmd_o,
  output logic [7:0] ad_o
);
  initial
  begin
    enable_n_o = 1'b1;
    rd_n_o = 1'b1;
    wr_n_o = 1'b1;
    cmd_o = 3'h7;
    ad_o = 8'hFF;
  end
  task automatic access(input logic wr, input logic [2:0] cmd, input logic [7:0] data,
      input int late, output logic [7:0] rdata, output logic ok);
    logic low;
    begin
      low = 1'b0;
      ok = 1'b0;
      @(posedge clk_i);
      #2;
      cmd_o = cmd;
      ad_o = data;
      enable_n_o = 1'b0;
      rd_n_o = wr;
      wr_n_o = !wr;
      for (int n = 0; n < 40 && !ok; n++)
      begin
        @(posedge clk_i);
        #1;
        ok = low && ack_i === 1'b1;
        low = low || ack_i === 1'b0;
      end
      rdata = ad_i;
      // Late release costs the device one more T-state
      repeat (late + 1) @(posedge clk_i);
      #2;
      enable_n_o = 1'b1;
      rd_n_o = 1'b1;
      wr_n_o = 1'b1;
      // Data outlives the strobe by a cycle
      @(posedge clk_i);
      #2;
      cmd_o = ~cmd;
      ad_o = ~data;
      repeat (5) @(posedge clk_i);
    end
  endtask : access
endmodule : host_model
`default_nettype wire

// >>> dv/remote_host_access_port_bench.sv
// Self-checking bench for the remote host access port
`timescale 1ns/1ps
`default_nettype none
module remote_host_access_port_bench;
  logic clk, rst, ack, local_bus_owned, ad_oe_n, ioe_n, iwr_n, dw_n, ok, oe_lclr, oe_pre, ioe;
  wire logic en_n, rd_n, wr_n;
  wire logic [2:0] cmd;
  wire logic [7:0] ad_host, ad_bus;
  wire logic [15:0] idata_i;
  logic [7:0] ad_dev, data_memory_d, cfg_o, rd, data_memory_seen, cfg;
  logic [15:0] ia, idata_o, ia_exp, ia_lclf, iword;
  logic en_q = 1'b1, ack_q = 1'b1, lcl_q = 1'b0, oe_q = 1'b0, dw_q = 1'b1, iw_q = 1'b1;
  int num_errors = 0, compares = 0, cyc = 0;
  int t_req, t_rel, t_ackf, t_ackr, t_lclr, t_lclf, t_adv, t_dwf, t_dwr, t_iwf;

  // Device drives the shared bus only while its enable is low
  assign ad_bus = !ad_oe_n ? ad_dev : ad_host;
  assign idata_i = {ia[7:0] ^ 8'hA5, ia[7:0]};

  host_model host (.clk_i(clk), .ack_i(ack), .ad_i(ad_bus), .enable_n_o(en_n), .rd_n_o(rd_n),
    .wr_n_o(wr_n), .cmd_o(cmd), .ad_o(ad_host));

  remote_host_access_port dut (.REF_CLK_I(clk), .RESET_I(rst), .REMOTE_ACCESS_ENABLE_N_I(en_n),
    .REMOTE_READ_STROBE_N_I(rd_n), .REMOTE_WRITE_STROBE_N_I(wr_n), .COMMAND_I(cmd),
    .AD_I(ad_bus), .AD_O(ad_dev), .AD_OE_N_O(ad_oe_n), .TRANSFER_WAIT_ACK_O(ack),
    .LOCAL_BUS_OWNED_O(local_bus_owned), .INSTRUCTION_ADDRESS_BUS_O(ia), .INSTR_DATA_I(idata_i),
    .INSTR_DATA_O(idata_o), .INSTR_DATA_OE_N_O(ioe_n), .INSTR_MEM_WRITE_STROBE_N_O(iwr_n),
    .DATA_MEM_WRITE_N_O(dw_n), .DATA_MEM_DATA_O(data_memory_d), .REMOTE_INTERFACE_CONFIG_O(cfg_o));

  initial
  begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  // Edge stamps of enable, ack, bus owned, bus enable and both write strobes, taken once the edge has settled
  always @(posedge clk)
  begin
    #1;
    cyc++;
    if (en_q && !en_n) t_req = cyc;
    if (!en_q && en_n) t_rel = cyc;
    if (ack_q && !ack) t_ackf = cyc;
    if (!ack_q && ack) t_ackr = cyc;
    if (!lcl_q && local_bus_owned) t_lclr = cyc;
    if (!lcl_q && local_bus_owned) oe_lclr = ad_oe_n;
    if (lcl_q && !local_bus_owned) t_lclf = cyc;
    if (lcl_q && !local_bus_owned) oe_pre = oe_q;
    if (lcl_q && !local_bus_owned) ia_lclf = ia;
    if (local_bus_owned && oe_q && !ad_oe_n) t_adv = cyc;
    if (dw_q && !dw_n) t_dwf = cyc;
    if (!dw_q && dw_n) data_memory_seen = data_memory_d;
    if (!dw_q && dw_n) t_dwr = cyc;
    if (iw_q && !iwr_n) t_iwf = cyc;
    if (!iw_q && iwr_n) iword = idata_o;
    if (iw_q && !iwr_n) ioe = ioe_n;
    {en_q, ack_q, lcl_q, oe_q, dw_q, iw_q} = {en_n, ack, local_bus_owned, ad_oe_n, dw_n, iwr_n};
  end

  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    begin
      compares++;
      if (got !== exp)
      begin
        num_errors++;
        $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      end
    end
  endtask : chk

  task automatic go(input logic wr, input logic [2:0] c, input logic [7:0] d, input int late);
    begin
      t_iwf = -1;
      host.access(wr, c, d, late, rd, ok);
      chk("done", 16'h0001, 16'(ok));
      chk("ack fall", 16'h0002, 16'(t_ackf - t_req));
      chk("seize", 16'(c == remote_port_pkg::CMD_INSTRUCTION_MEMORY ? 1 : cfg[5:4] + 1), 16'(t_lclr - t_ackf));
      chk("float", 16'h0001, 16'(oe_lclr));
      chk("redrive", 16'h0000, 16'(oe_pre));
    end
  endtask : go

  task automatic reset_values();
    begin
      chk("ack", 16'h0001, 16'(ack));
      chk("owned", 16'h0000, 16'(local_bus_owned));
      chk("ia", remote_port_pkg::IA_RESET, ia);
      chk("config", 16'(cfg), 16'(cfg_o));
    end
  endtask : reset_values

  task automatic pc_write();
    begin
      go(1'b1, remote_port_pkg::CMD_PC_LOW, 8'h40, 0);
      chk("pc own", 16'h0002, 16'(t_ackr - t_lclr));
      go(1'b1, remote_port_pkg::CMD_PC_HIGH, 8'h01, 0);
      ia_exp = 16'h0140;
      chk("pc", ia_exp, ia);
      go(1'b0, remote_port_pkg::CMD_PC_LOW, 8'h00, 0);
      chk("pc read", 16'h0040, 16'(rd));
    end
  endtask : pc_write

  task automatic instruction_memory_read();
    begin
      for (int k = 0; k < 2; k++)
      begin
        go(1'b0, remote_port_pkg::CMD_INSTRUCTION_MEMORY, 8'h00, 0);
        chk("byte", 16'(k ? ia_exp[7:0] ^ 8'hA5 : ia_exp[7:0]), 16'(rd));
        chk("byte delay", 16'h0001, 16'(t_adv - t_lclr));
        chk("byte valid", 16'(cfg[1:0] + 1), 16'(t_ackr - t_adv));
        chk("read ack", 16'(cfg[1:0] + 2), 16'(t_ackr - t_lclr));
        if (k) ia_exp = ia_exp + 16'h0001;
        chk("next ia", ia_exp, ia_lclf);
      end
    end
  endtask : instruction_memory_read

  task automatic instruction_memory_write();
    begin
      go(1'b1, remote_port_pkg::CMD_INSTRUCTION_MEMORY, 8'h34, 0);
      chk("low quiet", 16'hFFFF, 16'(t_iwf));
      chk("low own", 16'h0002, 16'(t_ackr - t_lclr));
      go(1'b1, remote_port_pkg::CMD_INSTRUCTION_MEMORY, 8'h12, 0);
      chk("word", 16'h1234, iword);
      chk("drive on", 16'h0000, 16'(ioe));
      chk("drive off", 16'h0001, 16'(ioe_n));
      chk("strobe delay", 16'h0001, 16'(t_iwf - t_lclr));
      chk("strobe low", 16'(cfg[1:0] + 1), 16'(t_ackr - t_iwf));
      chk("write ack", 16'(cfg[1:0] + 2), 16'(t_ackr - t_lclr));
      ia_exp = ia_exp + 16'h0001;
      chk("ia", ia_exp, ia);
    end
  endtask : instruction_memory_write

  task automatic data_memory_write(input int late, input logic [7:0] d);
    begin
      go(1'b1, remote_port_pkg::CMD_DATA_MEMORY, d, late);
      chk("data_memory data", 16'(d), 16'(data_memory_seen));
      chk("dstrobe delay", 16'h0001, 16'(t_dwf - t_lclr));
      chk("dstrobe ack", 16'(cfg[3:2] + 1), 16'(t_ackr - t_dwf));
      chk("dstrobe end", 16'h0002, 16'(t_dwr - t_rel));
      chk("release", 16'(late ? 4 : 3), 16'(t_lclf - t_rel));
    end
  endtask : data_memory_write

  task automatic config_write();
    begin
      go(1'b1, remote_port_pkg::CMD_CONFIG, 8'h2E, 0);
      cfg = 8'h2E;
      chk("config", 16'(cfg), 16'(cfg_o));
      go(1'b0, remote_port_pkg::CMD_CONFIG, 8'h00, 0);
      chk("config read", 16'(cfg), 16'(rd));
      go(1'b0, 3'h5, 8'h00, 0);
      chk("unknown read", 16'h0000, 16'(rd));
    end
  endtask : config_write

  task automatic tally_and_finish();
    begin
      $display("errors %0d compares %0d", num_errors, compares);
      if (num_errors == 0 && compares > 0)
        $display("Test passed");
      else
        $display("Test failed");
      $finish;
    end
  endtask : tally_and_finish

  initial
  begin
    rst = 1'b1;
    cfg = remote_port_pkg::CONFIG_RESET;
    repeat (12) @(posedge clk);
    #2;
    rst = 1'b0;
    reset_values();
    pc_write();
    instruction_memory_read();
    instruction_memory_write();
    data_memory_write(0, 8'h5C);
    data_memory_write(1, 8'hC3);
    config_write();
    instruction_memory_read();
    instruction_memory_write();
    data_memory_write(1, 8'hA7);
    tally_and_finish();
  end

  // Whole sequence needs well under a thousand cycles
  initial
  begin
    #200000;
    num_errors++;
    tally_and_finish();
  end
endmodule : remote_host_access_port_bench
`default_nettype wire
